// ===== hw/init_timer.sv
// Initialisation timeout timer, restarted by a one-cycle pulse.
// Assumes restart comes from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "lane_hs_consts.svh"
module init_timer #(
  parameter int unsigned TMO_CYC = `LHS_INIT_TMO_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic run,
  output logic      expired
);
  typedef struct packed {
    logic [15:0] count;
    logic        done;
  } tmr_s;
  tmr_s state_reg;
  tmr_s state_next;
  always_comb begin
    state_next = state_reg;
    if (restart || !run) begin
      state_next.count = 16'h0;
      state_next.done  = 1'b0;
    end else if (state_reg.count == 16'(TMO_CYC - 1)) begin
      state_next.done = 1'b1;
    end else begin
      state_next.count = state_reg.count + 16'h1;
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign expired = state_reg.done;
endmodule
`default_nettype wire

// ===== hw/lane_hs_consts.svh
// Constants for the lane start handshake block.
// Assumes inclusion by bare name from hw/ design files.
`ifndef LANE_HS_CONSTS_SVH
`define LANE_HS_CONSTS_SVH
`define LHS_CLK_MHZ        20
`define LHS_INIT_TMO_US    20
`define LHS_INIT_TMO_CYC   ((`LHS_INIT_TMO_US) * (`LHS_CLK_MHZ))
`define LHS_PAIR_COUNT     2
`define LHS_ERR_MORE_THAN  8
`define LHS_ERR_AT         8
`define LHS_ACK_SENT_MIN   16
`define LHS_WORD_W         3
`define LHS_WORD_NONE      3'h0
`define LHS_WORD_IDLE      3'h1
`define LHS_WORD_START     3'h2
`define LHS_WORD_ACK       3'h3
`define LHS_WORD_RECEIVE_ERROR_WORD     3'h4
`define LHS_WORD_OTHER     3'h5
`endif

// ===== hw/lane_hs_pkg.sv
// Types for the lane start handshake block.
// Assumes lane_hs_consts.svh for the numeric values.
package lane_hs_pkg;
  typedef enum logic [2:0] {
    ST_START      = 3'h0,
    ST_START_INV  = 3'h1,
    ST_LOCAL_SENT = 3'h3,
    ST_MUTUAL     = 3'h2,
    ST_ONE_ACKED  = 3'h6,
    ST_ACTIVE     = 3'h7,
    ST_FLUSH      = 3'h5,
    ST_FULL_RST   = 3'h4
  } lane_state_e;
  typedef logic [2:0] word_t;
endpackage

// ===== hw/lane_init_start_handshake.sv
// Lane start handshake: local-start-sent and mutual-start states.
// Assumes decoded lane control words arrive one per cycle with a valid strobe
// from receive logic on mclk; restart and no-signal levels come from pins.
//
// Contract
// - Start to local-sent after two idle words
// - Inverted start to local-sent after two idles
// - Local-sent sends start-request words repeatedly
// - Keep decoding control words in handshake
// - Exits checked in fixed priority order
// - Full restart wins, goes to full-restart
// - Soft restart goes to line flush
// - No signal goes to line flush
// - Local-sent: more than eight errors flush
// - Local-sent: two start-requests go mutual
// - Local-sent: two acks go one-side-acked
// - Timeout expiry goes to line flush
// - Start to mutual after two start-requests
// - Inverted start to mutual after two requests
// - Mutual state sends acknowledge words repeatedly
// - Mutual: eight errors go to flush
// - Mutual: two acks, sixteen sent, active
// - Init timeout lasts 20 microseconds
`timescale 1ns/1ps
`default_nettype none
`include "lane_hs_consts.svh"
module lane_init_start_handshake #(
  parameter int unsigned INIT_TMO_CYC = `LHS_INIT_TMO_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    fullPowerOnRestart,
  input  wire logic                    softRestart,
  input  wire logic                    noSignal,
  input  wire logic                    startEnable,
  input  wire logic                    invertedPolarity,
  input  wire logic                    rxWordValid,
  input  wire lane_hs_pkg::word_t      rxWord,
  input  wire logic                    txWordTaken,
  output lane_hs_pkg::word_t           txWord,
  output logic                         txWordValid,
  output lane_hs_pkg::lane_state_e     laneState,
  output logic                         laneActive,
  output logic                         initTimeout
);
  typedef struct packed {
    lane_hs_pkg::lane_state_e st;
    lane_hs_pkg::word_t       lastWord;
    logic [1:0]               pairCnt;
    logic [3:0]               errCnt;
    logic [4:0]               ackSent;
  } hs_s;

  hs_s  state_reg;
  hs_s  state_next;
  logic fullRstSync;
  logic softRstSync;
  logic noSigSync;
  logic tmoExpired;
  logic pairSeen;
  logic errOverMore;
  logic errOverAt;
  logic ackDone;
  logic inHandshake;
  logic tmrStart;

  // Pin levels cross into mclk before any decision reads them
  sync_2ff uSyncFull (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (fullPowerOnRestart),
    .dout    (fullRstSync)
  );
  sync_2ff uSyncSoft (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (softRestart),
    .dout    (softRstSync)
  );
  sync_2ff uSyncNoSig (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (noSignal),
    .dout    (noSigSync)
  );

  assign inHandshake = (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT) ||
                       (state_reg.st == lane_hs_pkg::ST_MUTUAL) ||
                       (state_reg.st == lane_hs_pkg::ST_ONE_ACKED);

  init_timer #(
    .TMO_CYC (INIT_TMO_CYC)
  ) uTimer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .restart (tmrStart),
    .run     (inHandshake),
    .expired (tmoExpired)
  );

  // Pair is complete when this valid word matches the previous one
  assign pairSeen = rxWordValid && (rxWord == state_reg.lastWord) &&
                    (state_reg.pairCnt == 2'(`LHS_PAIR_COUNT - 1));
  assign errOverMore = rxWordValid && (rxWord == `LHS_WORD_RECEIVE_ERROR_WORD) &&
                       (state_reg.errCnt == 4'(`LHS_ERR_MORE_THAN));
  assign errOverAt   = rxWordValid && (rxWord == `LHS_WORD_RECEIVE_ERROR_WORD) &&
                       (state_reg.errCnt == 4'(`LHS_ERR_AT - 1));
  assign ackDone = (state_reg.ackSent == 5'(`LHS_ACK_SENT_MIN));

  always_comb begin
    state_next = state_reg;
    // Word tracking runs in every state, so detection never stalls
    if (rxWordValid) begin
      if (rxWord == state_reg.lastWord) begin
        if (state_reg.pairCnt != 2'(`LHS_PAIR_COUNT)) begin
          state_next.pairCnt = state_reg.pairCnt + 2'h1;
        end
      end else begin
        state_next.lastWord = rxWord;
        state_next.pairCnt  = 2'h1;
      end
      if (rxWord == `LHS_WORD_RECEIVE_ERROR_WORD) begin
        if (state_reg.errCnt != 4'hf) begin
          state_next.errCnt = state_reg.errCnt + 4'h1;
        end
      end else begin
        state_next.errCnt = 4'h0;
      end
    end
    if (txWordValid && txWordTaken && state_reg.st == lane_hs_pkg::ST_MUTUAL && !ackDone) begin
      state_next.ackSent = state_reg.ackSent + 5'h1;
    end
    unique case (state_reg.st)
      lane_hs_pkg::ST_START, lane_hs_pkg::ST_START_INV: begin
        if (fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FULL_RST;
        end else if (startEnable) begin
          if (pairSeen && rxWord == `LHS_WORD_IDLE) begin
            state_next.st = lane_hs_pkg::ST_LOCAL_SENT;
          end else if (pairSeen && rxWord == `LHS_WORD_START) begin
            state_next.st = lane_hs_pkg::ST_MUTUAL;
          end else begin
            state_next.st = invertedPolarity ? lane_hs_pkg::ST_START_INV
                                             : lane_hs_pkg::ST_START;
          end
        end
      end
      lane_hs_pkg::ST_LOCAL_SENT: begin
        // First condition that holds wins
        if (fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FULL_RST;
        end else if (softRstSync) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end else if (noSigSync) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end else if (errOverMore) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end else if (pairSeen && rxWord == `LHS_WORD_START) begin
          state_next.st = lane_hs_pkg::ST_MUTUAL;
        end else if (pairSeen && rxWord == `LHS_WORD_ACK) begin
          state_next.st = lane_hs_pkg::ST_ONE_ACKED;
        end else if (tmoExpired) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end
      end
      lane_hs_pkg::ST_MUTUAL: begin
        if (fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FULL_RST;
        end else if (softRstSync || noSigSync) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end else if (errOverAt) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end else if (state_reg.lastWord == `LHS_WORD_ACK &&
                     state_reg.pairCnt == 2'(`LHS_PAIR_COUNT) && ackDone) begin
          state_next.st = lane_hs_pkg::ST_ACTIVE;
        end else if (tmoExpired) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end
      end
      lane_hs_pkg::ST_ONE_ACKED, lane_hs_pkg::ST_ACTIVE: begin
        // Downstream states belong to neighbouring logic; only restarts or no signal leave
        if (fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FULL_RST;
        end else if (softRstSync || noSigSync) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end
      end
      lane_hs_pkg::ST_FLUSH: begin
        if (fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FULL_RST;
        end else if (!softRstSync && !noSigSync) begin
          state_next.st = lane_hs_pkg::ST_START;
        end
      end
      lane_hs_pkg::ST_FULL_RST: begin
        if (!fullRstSync) begin
          state_next.st = lane_hs_pkg::ST_FLUSH;
        end
      end
    endcase
    if (state_next.st != state_reg.st) begin
      // Entry clears counts so a pair cannot straddle two states
      state_next.pairCnt    = 2'h0;
      state_next.lastWord   = `LHS_WORD_NONE;
      state_next.errCnt     = 4'h0;
      state_next.ackSent    = 5'h0;
    end
  end

  // Restart on the entry edge itself; a registered restart would let a
  // stale expiry of the previous state flush the new one
  assign tmrStart = (state_next.st != state_reg.st) &&
                    ((state_next.st == lane_hs_pkg::ST_LOCAL_SENT) ||
                     (state_next.st == lane_hs_pkg::ST_MUTUAL));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg    <= '0;
      state_reg.st <= lane_hs_pkg::ST_FULL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    unique case (state_reg.st)
      lane_hs_pkg::ST_LOCAL_SENT: txWord = `LHS_WORD_START;
      lane_hs_pkg::ST_MUTUAL:     txWord = `LHS_WORD_ACK;
      lane_hs_pkg::ST_ONE_ACKED:  txWord = `LHS_WORD_ACK;
      default:                    txWord = `LHS_WORD_IDLE;
    endcase
  end
  assign txWordValid = inHandshake;
  assign laneState   = state_reg.st;
  assign laneActive  = (state_reg.st == lane_hs_pkg::ST_ACTIVE);
  assign initTimeout = tmoExpired;

  AST_FULL_RST_WINS: assert property (@(posedge mclk) disable iff (sys_rst)
    (inHandshake && fullRstSync) |=> state_reg.st == lane_hs_pkg::ST_FULL_RST)
    else $error("full restart did not win");
  AST_SOFT_FLUSH: assert property (@(posedge mclk) disable iff (sys_rst)
    (inHandshake && state_reg.st != lane_hs_pkg::ST_ONE_ACKED && !fullRstSync && softRstSync)
    |=> state_reg.st == lane_hs_pkg::ST_FLUSH)
    else $error("soft restart did not flush");
  AST_NOSIG_FLUSH: assert property (@(posedge mclk) disable iff (sys_rst)
    ((state_reg.st == lane_hs_pkg::ST_LOCAL_SENT || state_reg.st == lane_hs_pkg::ST_MUTUAL) &&
     !fullRstSync && noSigSync)
    |=> state_reg.st == lane_hs_pkg::ST_FLUSH)
    else $error("no signal did not flush");
  AST_LOCAL_TX: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg.st == lane_hs_pkg::ST_LOCAL_SENT |-> txWord == `LHS_WORD_START && txWordValid)
    else $error("local state not sending start words");
  AST_MUTUAL_TX: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg.st == lane_hs_pkg::ST_MUTUAL |-> txWord == `LHS_WORD_ACK && txWordValid)
    else $error("mutual state not sending ack words");
  AST_ACTIVE_NEEDS_SENT: assert property (@(posedge mclk) disable iff (sys_rst)
    ($past(state_reg.st) == lane_hs_pkg::ST_MUTUAL && laneActive) |->
    $past(state_reg.ackSent) == 5'(`LHS_ACK_SENT_MIN))
    else $error("active reached before sixteen acks sent");
  AST_NO_EARLY_ACTIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_MUTUAL && !ackDone) |=> !laneActive)
    else $error("active reached with fewer than sixteen acks sent");
  AST_START_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
    ((state_reg.st == lane_hs_pkg::ST_START || state_reg.st == lane_hs_pkg::ST_START_INV) &&
     !fullRstSync && startEnable && pairSeen && rxWord == `LHS_WORD_IDLE)
    |=> state_reg.st == lane_hs_pkg::ST_LOCAL_SENT)
    else $error("two idle words did not reach local state");
  AST_LOCAL_ERR_FLUSH: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && !fullRstSync && !softRstSync &&
     !noSigSync && errOverMore) |=> state_reg.st == lane_hs_pkg::ST_FLUSH)
    else $error("ninth error word did not flush local state");
  AST_LOCAL_ERR_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && !fullRstSync && !softRstSync &&
     !noSigSync && !tmoExpired && rxWordValid && rxWord == `LHS_WORD_RECEIVE_ERROR_WORD &&
     state_reg.errCnt < 4'(`LHS_ERR_MORE_THAN))
    |=> state_reg.st == lane_hs_pkg::ST_LOCAL_SENT)
    else $error("local state flushed at eight error words or fewer");
  AST_LOCAL_TO_ONE_ACK: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && !fullRstSync && !softRstSync &&
     !noSigSync && pairSeen && rxWord == `LHS_WORD_ACK)
    |=> state_reg.st == lane_hs_pkg::ST_ONE_ACKED)
    else $error("two ack words did not reach one-side-acked state");
  AST_TMO_FLUSH: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && !fullRstSync && !softRstSync &&
     !noSigSync && !rxWordValid && tmoExpired) |=> state_reg.st == lane_hs_pkg::ST_FLUSH)
    else $error("timeout did not flush local state");
  AST_LOCAL_TO_MUTUAL: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && !fullRstSync && !softRstSync &&
     !noSigSync && pairSeen && rxWord == `LHS_WORD_START)
    |=> state_reg.st == lane_hs_pkg::ST_MUTUAL)
    else $error("two start words did not reach mutual state");
  AST_ERR_MUTUAL: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg.st == lane_hs_pkg::ST_MUTUAL && !fullRstSync && errOverAt)
    |=> state_reg.st == lane_hs_pkg::ST_FLUSH)
    else $error("eight errors did not flush mutual state");
  AST_ACK_SAT: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg.ackSent <= 5'(`LHS_ACK_SENT_MIN))
    else $error("sent ack count passed sixteen");
  COV_ACTIVE: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg.st == lane_hs_pkg::ST_MUTUAL ##1 laneActive);
  COV_ONE_ACK: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg.st == lane_hs_pkg::ST_LOCAL_SENT ##1 state_reg.st == lane_hs_pkg::ST_ONE_ACKED);
  COV_TMO: cover property (@(posedge mclk) disable iff (sys_rst)
    inHandshake && tmoExpired);
  COV_LOCAL_ERR: cover property (@(posedge mclk) disable iff (sys_rst)
    state_reg.st == lane_hs_pkg::ST_LOCAL_SENT && errOverMore);
endmodule
`default_nettype wire

// ===== hw/sync_2ff.sv
// Two flip-flop level synchroniser for pin inputs.
// Assumes an asynchronous active-high reset on the destination clock.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_s;
  sync_s state_reg;
  sync_s state_next;
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = din;
    state_next.stage2 = state_reg.stage1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign dout = state_reg.stage2;
endmodule
`default_nettype wire

// ===== tb/peer_lane_model.sv
// Peer lane start logic: sends lane control words on command, accepts ours.
// Assumes the bench calls send_word from its falling-edge stimulus.
`timescale 1ns/1ps
`default_nettype none
`include "lane_hs_consts.svh"
module peer_lane_model (
  input  wire logic               mclk,
  input  wire lane_hs_pkg::word_t txWord,
  input  wire logic               txWordValid,
  input  wire logic               takeEn,
  output lane_hs_pkg::word_t      rxWord,
  output logic                    rxWordValid,
  output logic                    txWordTaken
);
  // Slow peer: takeEn low stalls acceptance of the words we are sent
  assign txWordTaken = txWordValid & takeEn & (txWord !== `LHS_WORD_NONE);
  initial begin
    rxWord      = `LHS_WORD_NONE;
    rxWordValid = 1'b0;
  end
  // Between words the line shows the inverse, so a stale word never looks valid
  task automatic send_word(input lane_hs_pkg::word_t w);
    @(negedge mclk);
    rxWord      = w;
    rxWordValid = 1'b1;
    @(negedge mclk);
    rxWordValid = 1'b0;
    rxWord      = ~w;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the lane start handshake block.
// Assumes hw/ sources and the peer model; timeout shortened to TMO cycles.
`timescale 1ns/1ps
`default_nettype none
`include "lane_hs_consts.svh"
module tb;
  localparam int unsigned TMO = 40;
  logic                     mclk;
  logic                     sys_rst;
  logic                     fullPowerOnRestart;
  logic                     softRestart;
  logic                     noSignal;
  logic                     startEnable;
  logic                     invertedPolarity;
  logic                     rxWordValid;
  lane_hs_pkg::word_t       rxWord;
  logic                     txWordTaken;
  lane_hs_pkg::word_t       txWord;
  logic                     txWordValid;
  lane_hs_pkg::lane_state_e laneState;
  logic                     laneActive;
  logic                     initTimeout;
  logic                     takeEn;
  int                       fails;
  int                       n_tests;

  lane_init_start_handshake #(.INIT_TMO_CYC(TMO)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .fullPowerOnRestart(fullPowerOnRestart),
    .softRestart(softRestart), .noSignal(noSignal), .startEnable(startEnable),
    .invertedPolarity(invertedPolarity), .rxWordValid(rxWordValid), .rxWord(rxWord),
    .txWordTaken(txWordTaken), .txWord(txWord), .txWordValid(txWordValid),
    .laneState(laneState), .laneActive(laneActive), .initTimeout(initTimeout)
  );
  peer_lane_model peer (
    .mclk(mclk), .txWord(txWord), .txWordValid(txWordValid), .takeEn(takeEn),
    .rxWord(rxWord), .rxWordValid(rxWordValid), .txWordTaken(txWordTaken)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait; passing through state bad on the way is a mismatch
  task automatic wait_state(input lane_hs_pkg::lane_state_e s,
                            input lane_hs_pkg::lane_state_e bad);
    int i;
    for (i = 0; i < 20 && laneState !== s; i++) begin
      if (laneState === bad) check(laneState, s);
      @(negedge mclk);
    end
    check(laneState, s);
  endtask

  task automatic go_start(input logic inv);
    @(negedge mclk);
    {fullPowerOnRestart, softRestart, noSignal} = 3'h0;
    invertedPolarity = inv;
    takeEn = 1'b0;
    sys_rst = 1'b1;
    repeat (12) @(negedge mclk);
    check(laneState, lane_hs_pkg::ST_FULL_RST);
    sys_rst = 1'b0;
    wait_state(inv ? lane_hs_pkg::ST_START_INV : lane_hs_pkg::ST_START, lane_hs_pkg::ST_ACTIVE);
  endtask

  task automatic pair(input lane_hs_pkg::word_t w);
    peer.send_word(w);
    peer.send_word(w);
  endtask

  task automatic go_local(input logic inv);
    go_start(inv);
    pair(`LHS_WORD_IDLE);
    check(laneState, lane_hs_pkg::ST_LOCAL_SENT);
    check(txWord, `LHS_WORD_START);
    check(txWordValid, 1'b1);
  endtask

  task automatic t_mutual_entry;
    go_start(1'b1);
    pair(`LHS_WORD_START);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
    check(txWord, `LHS_WORD_ACK);
    go_start(1'b0);
    startEnable = 1'b0;
    pair(`LHS_WORD_IDLE);
    check(laneState, lane_hs_pkg::ST_START);
    startEnable = 1'b1;
    pair(`LHS_WORD_START);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
  endtask

  task automatic t_broken_pair;
    go_local(1'b0);
    peer.send_word(`LHS_WORD_START);
    peer.send_word(`LHS_WORD_IDLE);
    peer.send_word(`LHS_WORD_START);
    check(laneState, lane_hs_pkg::ST_LOCAL_SENT);
    peer.send_word(`LHS_WORD_START);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
    go_local(1'b1);
    pair(`LHS_WORD_ACK);
    check(laneState, lane_hs_pkg::ST_ONE_ACKED);
  endtask

  task automatic t_errors;
    go_local(1'b0);
    repeat (8) peer.send_word(`LHS_WORD_RECEIVE_ERROR_WORD);
    check(laneState, lane_hs_pkg::ST_LOCAL_SENT);
    peer.send_word(`LHS_WORD_RECEIVE_ERROR_WORD);
    check(laneState, lane_hs_pkg::ST_FLUSH);
    go_start(1'b0);
    pair(`LHS_WORD_START);
    repeat (7) peer.send_word(`LHS_WORD_RECEIVE_ERROR_WORD);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
    peer.send_word(`LHS_WORD_RECEIVE_ERROR_WORD);
    check(laneState, lane_hs_pkg::ST_FLUSH);
  endtask

  task automatic t_timeout;
    go_local(1'b0);
    repeat (TMO - 1) @(negedge mclk);
    check(laneState, lane_hs_pkg::ST_LOCAL_SENT);
    check(initTimeout, 1'b0);
    @(negedge mclk);
    check(initTimeout, 1'b1);
    wait_state(lane_hs_pkg::ST_FLUSH, lane_hs_pkg::ST_MUTUAL);
  endtask

  task automatic t_restarts;
    go_local(1'b0);
    {fullPowerOnRestart, softRestart, noSignal} = 3'h7;
    wait_state(lane_hs_pkg::ST_FULL_RST, lane_hs_pkg::ST_FLUSH);
    go_start(1'b0);
    pair(`LHS_WORD_START);
    {softRestart, noSignal} = 2'h3;
    wait_state(lane_hs_pkg::ST_FLUSH, lane_hs_pkg::ST_FULL_RST);
    go_local(1'b0);
    noSignal = 1'b1;
    wait_state(lane_hs_pkg::ST_FLUSH, lane_hs_pkg::ST_FULL_RST);
  endtask

  task automatic t_active;
    go_local(1'b0);
    // Words taken before entry must not count toward the sixteen
    takeEn = 1'b1;
    repeat (6) @(negedge mclk);
    takeEn = 1'b0;
    pair(`LHS_WORD_START);
    pair(`LHS_WORD_ACK);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
    takeEn = 1'b1;
    repeat (15) @(negedge mclk);
    takeEn = 1'b0;
    repeat (3) @(negedge mclk);
    check(laneState, lane_hs_pkg::ST_MUTUAL);
    takeEn = 1'b1;
    @(negedge mclk);
    takeEn = 1'b0;
    wait_state(lane_hs_pkg::ST_ACTIVE, lane_hs_pkg::ST_FLUSH);
    @(negedge mclk);
    check(laneActive, 1'b1);
  endtask

  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    {fullPowerOnRestart, softRestart, noSignal} = 3'h0;
    startEnable = 1'b1;
    invertedPolarity = 1'b0;
    takeEn = 1'b0;
    t_mutual_entry();
    t_broken_pair();
    t_errors();
    t_timeout();
    t_restarts();
    t_active();
    complete_run();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
